// ==== core/ric_pkg.sv ====
// Constants for the reset, interrupt and control pin block.
// Assumes a 40 MHz processor clock and an APB register port with 32-bit data.
package ric_pkg;
	// ==========================================================
	// Timing
	localparam int CLK_MHZ = 40;
	localparam int WD_PULSE_CYCLES = 8;
	localparam int WD_CNT_W = 4;
	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_SYS_STATUS_CONTROL_REG = 8'h00;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h04;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
	localparam logic [7:0] OFS_PIN_STAT = 8'h0c;
	// ==========================================================
	// System status and control fields
	localparam int B_X1_RISE = 0;
	localparam int B_X2_RISE = 1;
	localparam int B_CONV_EN = 2;
	localparam int B_FLAG_GPIO = 3;
	localparam int B_FLAG_DATA = 4;
	localparam int B_BR_GPIO = 5;
	localparam int B_BR_DIR = 6;
	localparam int B_BR_DATA = 7;
	localparam int B_CLK_SEL = 14;
	localparam int SYS_STATUS_CONTROL_REG_W = 15;
	localparam logic [SYS_STATUS_CONTROL_REG_W-1:0] SYS_STATUS_CONTROL_REG_RST = 15'h0000;
	// ==========================================================
	// Interrupt status and mask fields
	localparam int IRQ_W = 4;
	localparam int I_X1 = 0;
	localparam int I_X2 = 1;
	localparam int I_NMI = 2;
	localparam int I_WD = 3;
	localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
	// ==========================================================
	// Pin status fields
	localparam int P_FLAG = 0;
	localparam int P_BR = 1;
	localparam int P_X1 = 2;
	localparam int P_X2 = 3;
	localparam int P_NMI = 4;
	localparam int P_RST = 5;
	localparam int PIN_W = 6;
	localparam logic FLAG_RST = 1'b1;
endpackage

// ==== core/ric_sync.sv ====
// Two-stage synchroniser bank for asynchronous pins.
// Assumes pins settle between samples; the first stage is read only by the second.
`timescale 1ns/10ps
module ric_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '1
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;
	// ==========================================================
	// Stages
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			meta_r <= INIT;
			q_r <= INIT;
		end else begin
			meta_r <= i_d;
			q_r <= meta_r;
		end
	end
	assign o_q = q_r;
endmodule

// ==== core/ric_top.sv ====
// Reset, interrupt, flag, branch-test and clock-output pin logic.
// Assumes one 40 MHz clock, APB register access and board-driven asynchronous pins.
// Summary of operation
// RL1: While device reset is low, execution stops and the program counter is held at zero.
// RL2: When device reset rises, fetching restarts at program address zero.
// RL3: Device reset returns control registers and status bits to their reset values; the interrupt status and mask registers here clear only on the local reset.
// RL4: Watchdog overflow drives device reset low for eight clock cycles.
// RL5: The non-maskable interrupt ignores the global interrupt mask.
// RL6: NMI is a falling edge then low; driver keeps it low one cycle.
// RL7: Both external interrupts are edge triggered with programmable polarity.
// RL8: Driver holds the new external interrupt level at least one cycle.
// RL9: The second external interrupt can also start an ADC conversion.
// RL10: Software flag is latched and changes only on set or clear instructions.
// RL11: Every reset makes the flag pin the flag output driven high.
// RL12: Conditional branch samples branch-test input and branches when it is low.
// RL13: Every reset makes the branch-test pin a branch input; software may reassign.
// RL14: Clock output carries processor or watchdog clock, selected by control bit 14.
// RL15: Asynchronous interrupt and reset pins pass two flip-flops before detection.
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/10ps
module ric_top (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_device_reset_n,
	output logic o_device_reset_n,
	output logic o_device_reset_n_oe,
	input wire logic i_wd_overflow,
	output logic o_core_hold,
	output logic o_fetch_start,
	input wire logic i_nmi_n,
	input wire logic i_nmi_ack,
	output logic o_nmi_req,
	input wire logic i_global_irq_mask,
	input wire logic i_ext_irq_one,
	input wire logic i_ext_irq_two,
	output logic o_ext_irq_req,
	output logic o_conv_start_in,
	output logic o_irq,
	input wire logic i_set_control_bit_instr,
	input wire logic i_clear_control_bit_instr,
	input wire logic i_soft_flag_pin,
	output logic o_soft_flag_out,
	output logic o_soft_flag_oe,
	input wire logic i_conditional_branch_instr,
	input wire logic i_branch_test_in,
	output logic o_branch_test_out,
	output logic o_branch_test_oe,
	output logic o_branch_taken,
	input wire logic i_watchdog_clock,
	output logic o_clock_output_pin
);
	// ==========================================================
	// Input synchronisers
	logic [3:0] sync_q;
	logic rst_s, nmi_s, x1_s, x2_s;
	ric_sync #(.W(4), .INIT(4'hf)) u_sync (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_d({i_device_reset_n, i_nmi_n, i_ext_irq_one, i_ext_irq_two}), // RL15
		.o_q(sync_q)
	);
	assign {rst_s, nmi_s, x1_s, x2_s} = sync_q;

	// ==========================================================
	// Reset pulse and core hold
	logic [ric_pkg::WD_CNT_W-1:0] wd_cnt_r, wd_cnt_nxt;
	logic hold_r, hold_nxt;
	logic rst_all;
	// Own pulse counter uses only the local reset, else the pin loopback would cut it short
	always_comb begin
		wd_cnt_nxt = wd_cnt_r;
		if (i_wd_overflow && wd_cnt_r == '0) begin
			wd_cnt_nxt = ric_pkg::WD_CNT_W'(ric_pkg::WD_PULSE_CYCLES); // RL4
		end else if (wd_cnt_r != '0) begin
			wd_cnt_nxt = wd_cnt_r - 1'b1;
		end
	end
	assign rst_all = !i_nrst || !rst_s;
	assign hold_nxt = rst_all;
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			wd_cnt_r <= '0;
			hold_r <= 1'b1;
		end else begin
			wd_cnt_r <= wd_cnt_nxt;
			hold_r <= hold_nxt;
		end
	end
	assign o_device_reset_n = 1'b0;
	assign o_device_reset_n_oe = (wd_cnt_r != '0); // RL4
	assign o_core_hold = rst_all; // RL1
	assign o_fetch_start = hold_r && !rst_all; // RL2

	// ==========================================================
	// Edge detection
	logic nmi_d_r, x1_d_r, x2_d_r;
	logic nmi_arm_r, x1_arm_r, x2_arm_r;
	logic nmi_arm_nxt, x1_arm_nxt, x2_arm_nxt;
	logic nmi_pend_r, nmi_pend_nxt;
	logic ev_nmi, ev_x1, ev_x2;
	logic [ric_pkg::SYS_STATUS_CONTROL_REG_W-1:0] sys_status_control_reg_r, sys_status_control_reg_nxt;

	function automatic logic edge_sel(input logic prev, input logic cur, input logic rise);
		edge_sel = rise ? (!prev && cur) : (prev && !cur);
	endfunction

	// Edge is confirmed only when the new level is still there a cycle later
	always_comb begin
		nmi_arm_nxt = nmi_d_r && !nmi_s; // RL6
		x1_arm_nxt = edge_sel(x1_d_r, x1_s, sys_status_control_reg_r[ric_pkg::B_X1_RISE]); // RL7
		x2_arm_nxt = edge_sel(x2_d_r, x2_s, sys_status_control_reg_r[ric_pkg::B_X2_RISE]); // RL7
		ev_nmi = nmi_arm_r && !nmi_s; // RL6
		ev_x1 = x1_arm_r && (x1_s == sys_status_control_reg_r[ric_pkg::B_X1_RISE]); // RL8
		ev_x2 = x2_arm_r && (x2_s == sys_status_control_reg_r[ric_pkg::B_X2_RISE]); // RL8
		nmi_pend_nxt = (nmi_pend_r && !i_nmi_ack) || ev_nmi;
	end
	// Delay stages follow the synced pins in reset, else a low pin gives a false edge at release
	always_ff @(posedge i_clk) begin
		if (rst_all) begin
			nmi_d_r <= nmi_s;
			x1_d_r <= x1_s;
			x2_d_r <= x2_s;
			nmi_arm_r <= 1'b0;
			x1_arm_r <= 1'b0;
			x2_arm_r <= 1'b0;
			nmi_pend_r <= 1'b0;
		end else begin
			nmi_d_r <= nmi_s;
			x1_d_r <= x1_s;
			x2_d_r <= x2_s;
			nmi_arm_r <= nmi_arm_nxt;
			x1_arm_r <= x1_arm_nxt;
			x2_arm_r <= x2_arm_nxt;
			nmi_pend_r <= nmi_pend_nxt;
		end
	end
	assign o_nmi_req = nmi_pend_r; // RL5

	// ==========================================================
	// APB slave and registers
	logic [ric_pkg::IRQ_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
	logic [ric_pkg::IRQ_W-1:0] ev_vec;
	logic [ric_pkg::PIN_W-1:0] pin_vec;
	logic flag_r, flag_nxt;
	logic conv_r, conv_nxt, br_r, br_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic acc, hit, wr, rd;

	function automatic logic addr_hit(input logic [7:0] a);
		addr_hit = (a == ric_pkg::OFS_SYS_STATUS_CONTROL_REG) || (a == ric_pkg::OFS_IRQ_STAT) ||
			(a == ric_pkg::OFS_IRQ_MASK) || (a == ric_pkg::OFS_PIN_STAT);
	endfunction

	assign acc = i_psel && !i_penable;
	assign hit = addr_hit(i_paddr);
	assign wr = i_psel && i_penable && i_pwrite && hit;
	assign rd = i_psel && i_penable && !i_pwrite && hit;
	assign ev_vec = {1'b0, ev_nmi, ev_x2, ev_x1} |
		{i_wd_overflow && wd_cnt_r == '0, 3'b000};
	assign pin_vec = {rst_s, nmi_s, x2_s, x1_s, i_branch_test_in, flag_r};

	always_comb begin
		sys_status_control_reg_nxt = sys_status_control_reg_r;
		mask_nxt = mask_r;
		stat_nxt = stat_r;
		flag_nxt = flag_r;
		rdata_nxt = rdata_r;
		if (wr && i_paddr == ric_pkg::OFS_SYS_STATUS_CONTROL_REG) begin
			sys_status_control_reg_nxt = i_pwdata[ric_pkg::SYS_STATUS_CONTROL_REG_W-1:0];
		end
		if (wr && i_paddr == ric_pkg::OFS_IRQ_MASK) begin
			mask_nxt = i_pwdata[ric_pkg::IRQ_W-1:0];
		end
		if (rd && i_paddr == ric_pkg::OFS_IRQ_STAT) begin
			stat_nxt = '0;
		end
		stat_nxt = stat_nxt | ev_vec;
		if (i_set_control_bit_instr) begin
			flag_nxt = 1'b1; // RL10
		end else if (i_clear_control_bit_instr) begin
			flag_nxt = 1'b0; // RL10
		end
		if (acc) begin
			unique case (i_paddr)
				ric_pkg::OFS_SYS_STATUS_CONTROL_REG: rdata_nxt = 32'(sys_status_control_reg_r);
				ric_pkg::OFS_IRQ_STAT: rdata_nxt = 32'(stat_r);
				ric_pkg::OFS_IRQ_MASK: rdata_nxt = 32'(mask_r);
				ric_pkg::OFS_PIN_STAT: rdata_nxt = 32'(pin_vec);
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	// Local reset keeps a watchdog event visible after its own reset pulse
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			stat_r <= ric_pkg::IRQ_RST;
			mask_r <= ric_pkg::IRQ_RST;
			rdata_r <= 32'h0000_0000;
		end else begin
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			rdata_r <= rdata_nxt;
		end
	end
	always_ff @(posedge i_clk) begin
		if (rst_all) begin
			sys_status_control_reg_r <= ric_pkg::SYS_STATUS_CONTROL_REG_RST; // RL3 RL11 RL13
			flag_r <= ric_pkg::FLAG_RST; // RL11
		end else begin
			sys_status_control_reg_r <= sys_status_control_reg_nxt;
			flag_r <= flag_nxt;
		end
	end
	assign o_prdata = rdata_r;
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel && i_penable && !hit;
	assign o_irq = |(stat_r & mask_r);
	assign o_ext_irq_req = !i_global_irq_mask && |(stat_r[ric_pkg::I_X2:ric_pkg::I_X1] &
		mask_r[ric_pkg::I_X2:ric_pkg::I_X1]);

	// ==========================================================
	// Conversion start, branch test, flag pin, clock out
	assign conv_nxt = ev_x2 && sys_status_control_reg_r[ric_pkg::B_CONV_EN]; // RL9
	assign br_nxt = i_conditional_branch_instr && !sys_status_control_reg_r[ric_pkg::B_BR_GPIO] &&
		!i_branch_test_in; // RL12
	always_ff @(posedge i_clk) begin
		if (rst_all) begin
			conv_r <= 1'b0;
			br_r <= 1'b0;
		end else begin
			conv_r <= conv_nxt;
			br_r <= br_nxt;
		end
	end
	assign o_conv_start_in = conv_r;
	assign o_branch_taken = br_r;
	assign o_branch_test_oe = sys_status_control_reg_r[ric_pkg::B_BR_GPIO] && sys_status_control_reg_r[ric_pkg::B_BR_DIR]; // RL13
	assign o_branch_test_out = sys_status_control_reg_r[ric_pkg::B_BR_DATA];
	assign o_soft_flag_out = sys_status_control_reg_r[ric_pkg::B_FLAG_GPIO] ?
		sys_status_control_reg_r[ric_pkg::B_FLAG_DATA] : flag_r; // RL11
	assign o_soft_flag_oe = 1'b1;
	// Glitch-prone clock mux; switch only while the output is unused
	assign o_clock_output_pin = sys_status_control_reg_r[ric_pkg::B_CLK_SEL] ? i_watchdog_clock : i_clk; // RL14

	// ==========================================================
	// Assertions
	sequence s_wd_start;
		i_wd_overflow && wd_cnt_r == '0;
	endsequence
	property p_wd_pulse;
		@(posedge i_clk) disable iff (!i_nrst) s_wd_start |=> o_device_reset_n_oe [*8] ##1 !o_device_reset_n_oe;
	endproperty
	a_wd_pulse: assert property (p_wd_pulse) else $error("Reset pulse not eight cycles"); // RL4
	property p_hold;
		@(posedge i_clk) !rst_s |-> o_core_hold;
	endproperty
	a_hold: assert property (p_hold) else $error("Core not held in reset"); // RL1
	property p_fetch;
		@(posedge i_clk) disable iff (!i_nrst) $rose(rst_s) |-> o_fetch_start || o_core_hold;
	endproperty
	a_fetch: assert property (p_fetch) else $error("No fetch start at reset release"); // RL2
	property p_rst_regs;
		@(posedge i_clk) disable iff (!i_nrst) $past(!rst_s) |-> sys_status_control_reg_r == ric_pkg::SYS_STATUS_CONTROL_REG_RST && flag_r;
	endproperty
	a_rst_regs: assert property (p_rst_regs) else $error("Control not reset"); // RL3
	property p_nmi;
		@(posedge i_clk) disable iff (rst_all) $fell(nmi_s) ##1 !nmi_s |=> o_nmi_req;
	endproperty
	a_nmi: assert property (p_nmi) else $error("NMI not raised"); // RL5
	property p_nmi_glitch;
		@(posedge i_clk) disable iff (rst_all) $fell(nmi_s) ##1 nmi_s |=> !ev_nmi;
	endproperty
	a_nmi_glitch: assert property (p_nmi_glitch) else $error("Short NMI accepted"); // RL6
	property p_x1_edge;
		@(posedge i_clk) disable iff (rst_all) ev_x1 |-> $past(x1_s, 2) != x1_s && $past(x1_s) == x1_s;
	endproperty
	a_x1_edge: assert property (p_x1_edge) else $error("Bad ext one edge"); // RL7
	property p_conv;
		@(posedge i_clk) disable iff (rst_all) ev_x2 && sys_status_control_reg_r[ric_pkg::B_CONV_EN] |=> o_conv_start_in;
	endproperty
	a_conv: assert property (p_conv) else $error("No conversion start"); // RL9
	property p_flag;
		@(posedge i_clk) disable iff (rst_all) !i_set_control_bit_instr && !i_clear_control_bit_instr
			|=> $stable(flag_r);
	endproperty
	a_flag: assert property (p_flag) else $error("Flag changed without instruction"); // RL10
	property p_branch;
		@(posedge i_clk) disable iff (rst_all) i_conditional_branch_instr && !i_branch_test_in &&
			!sys_status_control_reg_r[ric_pkg::B_BR_GPIO] |=> o_branch_taken;
	endproperty
	a_branch: assert property (p_branch) else $error("Branch not taken on low input"); // RL12
endmodule

// ==== sim/ric_board.sv ====
// Board model: drives the reset, NMI and external interrupt lines.
// Assumes the design pulls the reset pin low only while its enable is high.
`timescale 1ns/10ps
module ric_board (
	input wire logic i_clk,
	input wire logic i_drv,
	input wire logic i_oe,
	output logic o_rst_pin,
	output logic o_nmi_n,
	output logic [1:0] o_x
);
	// ==========================================
	// Pins
	logic rst_n = 1'b1;
	initial begin
		o_nmi_n = 1'b1;
		o_x = 2'b11;
	end
	// Pull-up keeps the reset pin high while nobody drives it
	assign o_rst_pin = i_oe ? i_drv : rst_n;
	task automatic nmi(input int n);
		@(posedge i_clk) o_nmi_n <= 1'b0;
		repeat (n) @(posedge i_clk);
		o_nmi_n <= 1'b1;
	endtask
	// New level is held a few cycles so the core can confirm it
	task automatic xset(input int w, input logic v);
		@(posedge i_clk) o_x[w] <= v;
		repeat (3) @(posedge i_clk);
	endtask
	task automatic rst(input int n);
		@(posedge i_clk) rst_n <= 1'b0;
		repeat (n) @(posedge i_clk);
		rst_n <= 1'b1;
	endtask
endmodule

// ==== sim/test_ric_top.sv ====
// Self-checking bench for the reset, interrupt and control pin block.
// Assumes the board model ric_board and zero-wait APB answers.
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
	$display("[ERR] %0t got %h exp %h", $time, a, e); end end
`define WAITF(c) for (int k = 0; k < 12 && !(c); k++) begin @(posedge clk); #1; end
module test_ric_top;
	// ==========================================
	// Signals
	logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, wd = 0, nack = 0, gmask = 0;
	logic setf = 0, clrf = 0, bri = 0, brt = 1, watchdog_clock = 0, err;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q;
	logic pready, perr, rdrv, roe, rpin, nmi_n, hold, fst, nreq, xreq, conv, irq;
	logic flag, foe, bout, boe, btk, ckout;
	logic [1:0] x;
	int n_fail = 0, n_checks = 0, n_conv = 0, cyc = 0, n;
	ric_top ric_top_inst (.i_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(perr), .i_device_reset_n(rpin),
		.o_device_reset_n(rdrv), .o_device_reset_n_oe(roe), .i_wd_overflow(wd),
		.o_core_hold(hold), .o_fetch_start(fst), .i_nmi_n(nmi_n), .i_nmi_ack(nack),
		.o_nmi_req(nreq), .i_global_irq_mask(gmask), .i_ext_irq_one(x[0]),
		.i_ext_irq_two(x[1]), .o_ext_irq_req(xreq), .o_conv_start_in(conv), .o_irq(irq),
		.i_set_control_bit_instr(setf), .i_clear_control_bit_instr(clrf),
		.i_soft_flag_pin(flag), .o_soft_flag_out(flag), .o_soft_flag_oe(foe),
		.i_conditional_branch_instr(bri), .i_branch_test_in(brt),
		.o_branch_test_out(bout), .o_branch_test_oe(boe), .o_branch_taken(btk),
		.i_watchdog_clock(watchdog_clock), .o_clock_output_pin(ckout));
	ric_board ric_board_inst (.i_clk(clk), .i_drv(rdrv), .i_oe(roe), .o_rst_pin(rpin),
		.o_nmi_n(nmi_n), .o_x(x));
	initial forever #12.5 clk = ~clk;
	initial forever #37 watchdog_clock = ~watchdog_clock;
	// Run should take well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (conv === 1'b1) n_conv++;
		if (cyc == 3000) begin
			n_fail++;
			summarize();
		end
	end
	// ==========================================
	// Tasks
	task automatic summarize();
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
		@(posedge clk) pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		err = perr;
		psel <= 1'b0; pen <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(q, e)
	endtask
	// One-cycle strobe: 4 ack, 3 overflow, 2 set, 1 clear, 0 branch
	task automatic pulse(input int s, input logic v);
		@(posedge clk) {nack, wd, setf, clrf, bri} <= 5'h1 << s;
		brt <= v;
		@(posedge clk) {nack, wd, setf, clrf, bri} <= 5'h0;
		#1;
	endtask
	// ==========================================
	// Tests
	initial begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		#1 `WAITF(fst === 1'b1)
		`CHK(fst, 1'b1)
		`CHK(boe, 1'b0)
		`CHK(foe, 1'b1)
		rd(ric_pkg::OFS_SYS_STATUS_CONTROL_REG, 32'h0);
		rd(ric_pkg::OFS_IRQ_MASK, 32'h0);
		rd(8'h10, 32'h0);
		`CHK(err, 1'b1)
		$display("test reset done");
		pulse(1, 1'b1); `CHK(flag, 1'b0)
		repeat (4) @(posedge clk);
		#1 `CHK(flag, 1'b0)
		pulse(2, 1'b1); `CHK(flag, 1'b1)
		for (int b = 0; b < 2; b++) begin
			pulse(0, b[0]); `CHK(btk, ~b[0])
		end
		pulse(1, 1'b1);
		apb(1'b1, ric_pkg::OFS_SYS_STATUS_CONTROL_REG, 32'h1 << ric_pkg::B_CLK_SEL);
		repeat (4) begin @(watchdog_clock); #1 `CHK(ckout, watchdog_clock) end
		apb(1'b1, ric_pkg::OFS_SYS_STATUS_CONTROL_REG, 32'h0);
		repeat (4) begin @(clk); #1 `CHK(ckout, clk) end
		$display("test flag branch clock done");
		pulse(3, 1'b1);
		n = 0;
		repeat (12) begin if (roe === 1'b1) n++; @(posedge clk); #1; end
		`CHK(n, 8)
		repeat (6) @(posedge clk);
		#1 `CHK(flag, 1'b1)
		`CHK(irq, 1'b0)
		apb(1'b1, ric_pkg::OFS_IRQ_MASK, 32'h8);
		#1 `CHK(irq, 1'b1)
		rd(ric_pkg::OFS_IRQ_STAT, 32'h8);
		#1 `CHK(irq, 1'b0)
		$display("test watchdog done");
		@(posedge clk) gmask <= 1'b1;
		ric_board_inst.nmi(2);
		#1 `WAITF(nreq === 1'b1)
		`CHK(nreq, 1'b1)
		pulse(4, 1'b1); `CHK(nreq, 1'b0)
		rd(ric_pkg::OFS_IRQ_STAT, 32'h4);
		@(posedge clk) gmask <= 1'b0;
		for (int w = 0; w < 2; w++) for (int p = 1; p >= 0; p--) begin
			apb(1'b1, ric_pkg::OFS_SYS_STATUS_CONTROL_REG, (32'(p) << w) | (32'h1 << ric_pkg::B_CONV_EN));
			apb(1'b1, ric_pkg::OFS_IRQ_MASK, 32'h1 << w);
			ric_board_inst.xset(w, ~p[0]);
			rd(ric_pkg::OFS_IRQ_STAT, 32'h0);
			ric_board_inst.xset(w, p[0]);
			#1 `WAITF(irq === 1'b1)
			`CHK(xreq, 1'b1)
			rd(ric_pkg::OFS_IRQ_STAT, 32'h1 << w);
			#1 `CHK(irq, 1'b0)
		end
		`CHK(n_conv, 2)
		$display("test interrupts done");
		apb(1'b1, ric_pkg::OFS_SYS_STATUS_CONTROL_REG, 32'he0);
		#1 `CHK(boe, 1'b1)
		`CHK(bout, 1'b1)
		ric_board_inst.rst(5);
		#1 `CHK(hold, 1'b1)
		`WAITF(fst === 1'b1)
		`CHK(fst, 1'b1)
		rd(ric_pkg::OFS_SYS_STATUS_CONTROL_REG, 32'h0);
		`CHK(boe, 1'b0)
		$display("test pin reset done");
		summarize();
	end
endmodule
